// ===== scrf_consts.vh
// constants for the serial channel receive fifo and idle block
`ifndef SCRF_CONSTS_VH
`define SCRF_CONSTS_VH

// register indices on the plain port
`define SCRF_ADDR_W        4
`define SCRF_REG_CTRL      4'h0
`define SCRF_REG_STATUS    4'h1
`define SCRF_REG_FIFO_IN   4'h2
`define SCRF_REG_FIFO_OUT  4'h3
`define SCRF_REG_RXCFG     4'h4
`define SCRF_REG_PINCTRL   4'h5
`define SCRF_REG_FILLCNT   4'h6

// control register fields
`define SCRF_CTRL_MODE_LSB 0
`define SCRF_CTRL_MODE_MSB 3
`define SCRF_CTRL_TRAPEN   4
`define SCRF_CTRL_TXFIFO   5

// protocol select codes: off, and the highest code that enables the channel
`define SCRF_MODE_OFF      4'h0
`define SCRF_MODE_MAX      4'h4

// status register fields
`define SCRF_ST_IDLE       0
`define SCRF_ST_PARERR     1
`define SCRF_ST_FRMERR     2
`define SCRF_ST_EMPTY      3
`define SCRF_ST_FULL       4
`define SCRF_ST_RXBLOCK    5
`define SCRF_ST_ENABLED    6

// pin control register fields
`define SCRF_PIN_LEVEL     0
`define SCRF_PIN_DRVEN     1
`define SCRF_PIN_ALTSEL    2

// buffer geometry and widths
`define SCRF_DATA_W        16
`define SCRF_RAM_DEPTH     64
`define SCRF_PTR_W         6
`define SCRF_SIZE_RST      7'h10

// idle detection: bit times of high line that count as idle
`define SCRF_IDLE_BITS     4'hA
// bit time in clock cycles
`define SCRF_BIT_CYC       16'h0015

`endif

// ===== scrf_channel.v
// serial channel: receive fifo in parity ram, protocol enable, pin handover, idle detection
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "scrf_consts.vh"

// Notes on behaviour
// - fifo configured, not yet filled once, read empties it: false parity error may show
// - after receive count reaches configured size, no false parity indication
// - parity error raises buffer ram trap request only when trap is enabled
// - protocol codes 0001 to 0100 enable the channel; alternate output only then
// - clearing the idle flag blocks reception until the line is idle again
// - a frame starting before idle is set again is flagged as an error
module scrf_channel (
    // clock and reset
    input  wire                      clk,
    input  wire                      rst_n,
    // register port
    input  wire [`SCRF_ADDR_W-1:0]   addr,
    input  wire [`SCRF_DATA_W-1:0]   wdata,
    input  wire                      wr,
    input  wire                      rd,
    output reg  [`SCRF_DATA_W-1:0]   rdata,
    // serial line
    input  wire                      rx_line,
    output reg                       tx_pin_o,
    output reg                       tx_pin_oe,
    // trap request to the system
    output reg                       ram_trap_req
);

// ---------------------------------------------------------------------
// reset release
// ---------------------------------------------------------------------
reg rst_s1_reg;
reg rst_s2_reg;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rst_s1_reg <= 1'b0;
        rst_s2_reg <= 1'b0;
    end else begin
        rst_s1_reg <= 1'b1;
        rst_s2_reg <= rst_s1_reg;
    end
end
wire rst_i_n = rst_s2_reg;

// ---------------------------------------------------------------------
// registers
// ---------------------------------------------------------------------
reg  [3:0]               mode_reg;
reg                      trap_en_reg;
reg                      tx_fifo_reg;
reg  [6:0]               size_reg;
reg  [2:0]               pin_reg;
reg                      idle_reg;
reg                      par_err_reg;
reg                      frm_err_reg;
reg  [6:0]               fill_cnt_reg;

wire                     wr_ctrl  = wr && (addr == `SCRF_REG_CTRL);
wire                     wr_stat  = wr && (addr == `SCRF_REG_STATUS);
wire                     wr_in    = wr && (addr == `SCRF_REG_FIFO_IN);
wire                     rd_out   = rd && (addr == `SCRF_REG_FIFO_OUT);

wire chan_en = (mode_reg != `SCRF_MODE_OFF) && (mode_reg <= `SCRF_MODE_MAX);

// ---------------------------------------------------------------------
// buffer ram with one parity bit per word
// ---------------------------------------------------------------------
reg  [`SCRF_DATA_W:0]    ram [0:`SCRF_RAM_DEPTH-1];
reg  [`SCRF_PTR_W-1:0]   wptr_reg;
reg  [`SCRF_PTR_W-1:0]   rptr_reg;
reg  [6:0]               count_reg;
reg  [`SCRF_DATA_W-1:0]  out_reg;

wire [6:0] cap      = (size_reg > 7'd64 || size_reg == 7'd0) ? 7'd64 : size_reg;
wire       empty    = (count_reg == 7'd0);
wire       full     = (count_reg >= cap);

// receive shifter results
reg                      rx_done;
reg  [7:0]               rx_byte;

// a write into the fifo comes from software in transmit mode or from the receiver
wire sw_push = wr_in && tx_fifo_reg && !full;
wire rx_push = rx_done && !tx_fifo_reg && !full;
wire push    = sw_push || rx_push;
wire [`SCRF_DATA_W-1:0] push_data = sw_push ? wdata : {8'h00, rx_byte};
wire pop     = rd_out && !empty;

// ram read word and its parity check
wire [`SCRF_DATA_W:0] rd_word = ram[rptr_reg];
wire par_bad = ^rd_word;

// ram holds no reset so uninitialised words may fail parity, which is the hazard
always @(posedge clk) begin
    if (push) begin
        ram[wptr_reg] <= {^push_data, push_data};
    end
end

// ram never filled once: the read that empties it also looks ahead at a stale word
wire not_filled  = (fill_cnt_reg < size_reg);
wire spurious    = !tx_fifo_reg && not_filled && pop && (count_reg == 7'd1)
                   && ram[rptr_reg + 6'd1][`SCRF_DATA_W];
wire parity_evt  = (pop && par_bad) || spurious;

always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
        wptr_reg     <= {`SCRF_PTR_W{1'b0}};
        rptr_reg     <= {`SCRF_PTR_W{1'b0}};
        count_reg    <= 7'h00;
        out_reg      <= {`SCRF_DATA_W{1'b0}};
        ram_trap_req <= 1'b0;
    end else begin
        if (push) begin
            wptr_reg <= wptr_reg + 6'd1;
        end
        if (pop) begin
            rptr_reg <= rptr_reg + 6'd1;
            out_reg  <= rd_word[`SCRF_DATA_W-1:0];
        end
        if (push && !pop) begin
            count_reg <= count_reg + 7'd1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 7'd1;
        end
        ram_trap_req <= parity_evt && trap_en_reg;
    end
end

// ---------------------------------------------------------------------
// control, status and fill counter
// ---------------------------------------------------------------------
reg idle_set;
reg frame_start;

always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
        mode_reg     <= `SCRF_MODE_OFF;
        trap_en_reg  <= 1'b0;
        tx_fifo_reg  <= 1'b0;
        size_reg     <= `SCRF_SIZE_RST;
        pin_reg      <= 3'h1;
        idle_reg     <= 1'b0;
        par_err_reg  <= 1'b0;
        frm_err_reg  <= 1'b0;
        fill_cnt_reg <= 7'h00;
    end else begin
        if (wr_ctrl) begin
            mode_reg    <= wdata[`SCRF_CTRL_MODE_MSB:`SCRF_CTRL_MODE_LSB];
            trap_en_reg <= wdata[`SCRF_CTRL_TRAPEN];
            tx_fifo_reg <= wdata[`SCRF_CTRL_TXFIFO];
        end
        if (wr && addr == `SCRF_REG_RXCFG) begin
            size_reg <= wdata[6:0];
        end
        if (wr && addr == `SCRF_REG_PINCTRL) begin
            pin_reg <= wdata[2:0];
        end
        // fill count saturates; it only ever grows since power-up
        if (rx_push && fill_cnt_reg != 7'h7F) begin
            fill_cnt_reg <= fill_cnt_reg + 7'd1;
        end
        // hardware set wins over a software clear in the same cycle
        if (idle_set) begin
            idle_reg <= 1'b1;
        end else if (wr_stat && !wdata[`SCRF_ST_IDLE]) begin
            idle_reg <= 1'b0;
        end
        if (parity_evt) begin
            par_err_reg <= 1'b1;
        end else if (wr_stat && wdata[`SCRF_ST_PARERR]) begin
            par_err_reg <= 1'b0;
        end
        if (frame_start && !idle_reg) begin
            frm_err_reg <= 1'b1;
        end else if (wr_stat && wdata[`SCRF_ST_FRMERR]) begin
            frm_err_reg <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------------
// receiver: idle detection and byte shifter
// ---------------------------------------------------------------------
localparam RX_IDLE  = 2'b00;
localparam RX_DATA  = 2'b01;
localparam RX_STOP  = 2'b10;
localparam RX_START = 2'b11;

reg  [1:0]  rx_state_reg;
reg  [15:0] bit_cnt_reg;
reg  [3:0]  idle_cnt_reg;
reg  [2:0]  bit_idx_reg;
reg  [7:0]  shift_reg;
reg         rx_prev_reg;
reg         blocked_reg;

// the counter runs 0 to one less than a bit time, so a bit lasts exactly that many cycles
wire bit_tick = (bit_cnt_reg == `SCRF_BIT_CYC - 16'h0001);
wire half_tick = (bit_cnt_reg == (`SCRF_BIT_CYC >> 1));

always @* begin
    idle_set    = chan_en && rx_line && bit_tick && (idle_cnt_reg == `SCRF_IDLE_BITS)
                  && !idle_reg;
    frame_start = chan_en && (rx_state_reg == RX_IDLE) && rx_prev_reg && !rx_line;
end

always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
        rx_state_reg <= RX_IDLE;
        bit_cnt_reg  <= 16'h0000;
        idle_cnt_reg <= 4'h0;
        bit_idx_reg  <= 3'h0;
        shift_reg    <= 8'h00;
        rx_prev_reg  <= 1'b1;
        blocked_reg  <= 1'b1;
        rx_done      <= 1'b0;
        rx_byte      <= 8'h00;
    end else begin
        rx_prev_reg <= rx_line;
        rx_done     <= 1'b0;
        bit_cnt_reg <= bit_tick ? 16'h0000 : bit_cnt_reg + 16'h0001;
        // a software clear restarts the idle count, so idle must be seen afresh
        if (!rx_line || !chan_en || (wr_stat && !wdata[`SCRF_ST_IDLE])) begin
            idle_cnt_reg <= 4'h0;
        end else if (bit_tick && idle_cnt_reg != `SCRF_IDLE_BITS) begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
        // reception stays off until idle is seen after a clear
        if (!idle_reg) begin
            blocked_reg <= 1'b1;
        end else begin
            blocked_reg <= 1'b0;
        end
        case (rx_state_reg)
            RX_IDLE: begin
                if (frame_start && !blocked_reg && idle_reg) begin
                    rx_state_reg <= RX_START;
                    bit_cnt_reg  <= 16'h0000;
                    bit_idx_reg  <= 3'h0;
                end
            end
            // start bit is let pass whole, so data samples fall mid-bit
            RX_START: begin
                if (bit_tick) begin
                    rx_state_reg <= RX_DATA;
                end
            end
            RX_DATA: begin
                if (half_tick) begin
                    shift_reg <= {rx_line, shift_reg[7:1]};
                end
                if (bit_tick) begin
                    bit_idx_reg <= bit_idx_reg + 3'h1;
                    if (bit_idx_reg == 3'h7) begin
                        rx_state_reg <= RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (bit_tick) begin
                    rx_state_reg <= RX_IDLE;
                    rx_done      <= 1'b1;
                    rx_byte      <= shift_reg;
                end
            end
            default: begin
                rx_state_reg <= RX_IDLE;
            end
        endcase
    end
end

// ---------------------------------------------------------------------
// pin handover and read data
// ---------------------------------------------------------------------
// the pin follows the channel only when it is enabled and alternate is selected;
// otherwise the software level stands, which is what keeps handover spike free
always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
        tx_pin_o  <= 1'b1;
        tx_pin_oe <= 1'b0;
        rdata     <= {`SCRF_DATA_W{1'b0}};
    end else begin
        tx_pin_oe <= pin_reg[`SCRF_PIN_DRVEN];
        if (pin_reg[`SCRF_PIN_ALTSEL] && chan_en) begin
            tx_pin_o <= 1'b1;
        end else begin
            tx_pin_o <= pin_reg[`SCRF_PIN_LEVEL];
        end
        rdata <= {`SCRF_DATA_W{1'b0}};
        if (rd) begin
            case (addr)
                `SCRF_REG_CTRL:     rdata <= {10'h000, tx_fifo_reg, trap_en_reg, mode_reg};
                `SCRF_REG_STATUS:   rdata <= {9'h000, chan_en, blocked_reg, full, empty,
                                              frm_err_reg, par_err_reg, idle_reg};
                `SCRF_REG_FIFO_OUT: rdata <= empty ? {`SCRF_DATA_W{1'b0}}
                                                   : rd_word[`SCRF_DATA_W-1:0];
                `SCRF_REG_RXCFG:    rdata <= {9'h000, size_reg};
                `SCRF_REG_PINCTRL:  rdata <= {13'h0000, pin_reg};
                `SCRF_REG_FILLCNT:  rdata <= {9'h000, fill_cnt_reg};
                default:            rdata <= {`SCRF_DATA_W{1'b0}};
            endcase
        end
    end
end

endmodule

// ===== scrf_line_peer.sv
// serial line peer that sends 8N1 frames, lsb first, idling high
`timescale 1ns/1ps
`include "scrf_consts.vh"
module scrf_line_peer (
    // clock
    input  wire logic       clk,
    // frame request from the bench
    input  wire logic       go,
    input  wire logic [7:0] data,
    // serial line
    output logic            line,
    output logic            busy
);
    logic [9:0] frame;
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    always @(posedge clk) begin
        if (go) begin
            frame = {1'b1, data, 1'b0};
            busy <= 1'b1;
            for (int i = 0; i < 10; i++) begin
                line <= frame[i];
                repeat (`SCRF_BIT_CYC) @(posedge clk);
            end
            busy <= 1'b0;
        end
    end
endmodule

// ===== scrf_chk_asserts.sv
// port-level checker for the serial channel block
`timescale 1ns/1ps
`include "scrf_consts.vh"
module scrf_chk (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rst_n,
    // register port
    input wire logic [`SCRF_ADDR_W-1:0] addr,
    input wire logic [`SCRF_DATA_W-1:0] wdata,
    input wire logic                    wr,
    input wire logic                    rd,
    input wire logic [`SCRF_DATA_W-1:0] rdata,
    // line, pin and trap
    input wire logic                    rx_line,
    input wire logic                    tx_pin_o,
    input wire logic                    tx_pin_oe,
    input wire logic                    ram_trap_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic       trap_en_reg;
    logic [3:0] mode_reg;
    logic       mode_ok;
    assign mode_ok = (mode_reg != 4'h0) && (mode_reg <= `SCRF_MODE_MAX);
    // shadow of the mode and trap enable fields, seen only through writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_en_reg <= 1'b0;
            mode_reg    <= 4'h0;
        end else if (wr && addr == `SCRF_REG_CTRL) begin
            trap_en_reg <= wdata[`SCRF_CTRL_TRAPEN];
            mode_reg    <= wdata[`SCRF_CTRL_MODE_MSB:`SCRF_CTRL_MODE_LSB];
        end
    end
    sequence s_pop;
        rd && addr == `SCRF_REG_FIFO_OUT;
    endsequence
    sequence s_clear;
        wr && addr == `SCRF_REG_STATUS && !wdata[`SCRF_ST_IDLE];
    endsequence
    sequence s_rd_st;
        rd && addr == `SCRF_REG_STATUS;
    endsequence
    property p_trap_cause;
        ram_trap_req |-> $past(rd) && $past(addr) == `SCRF_REG_FIFO_OUT && $past(trap_en_reg);
    endproperty
    a_trap_cause: assert property (p_trap_cause) else $error("trap without enabled pop");
    property p_trap_off;
        s_pop and !trap_en_reg |=> !ram_trap_req;
    endproperty
    a_trap_off: assert property (p_trap_off) else $error("trap while disabled");
    property p_trap_pulse;
        ram_trap_req && !(rd && addr == `SCRF_REG_FIFO_OUT) |=> !ram_trap_req;
    endproperty
    a_trap_pulse: assert property (p_trap_pulse) else $error("trap longer than one cycle");
    property p_enabled;
        s_rd_st |=> rdata[`SCRF_ST_ENABLED] == $past(mode_ok);
    endproperty
    a_enabled: assert property (p_enabled) else $error("enable bit wrong for mode");
    property p_idle_clr;
        s_clear ##2 s_rd_st |=> !rdata[`SCRF_ST_IDLE] && rdata[`SCRF_ST_RXBLOCK];
    endproperty
    a_idle_clr: assert property (p_idle_clr) else $error("receiver not blocked");
    property p_rd_quiet;
        !rd |=> rdata == '0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");
endmodule
bind scrf_channel scrf_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_line(rx_line), .tx_pin_o(tx_pin_o),
    .tx_pin_oe(tx_pin_oe), .ram_trap_req(ram_trap_req));

// ===== tb.sv
// self-checking bench for the serial channel block
`timescale 1ns/1ps
`include "scrf_consts.vh"
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        rx_line;
    logic        tx_pin_o;
    logic        tx_pin_oe;
    logic        ram_trap_req;
    logic        go = 1'b0;
    logic [7:0]  byte_q = 8'h00;
    logic        busy;
    int          errors = 0;
    int          n_tests = 0;
    int          traps = 0;
    always #12.5 clk = ~clk;
    scrf_channel u_scrf_channel (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rx_line(rx_line), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
        .ram_trap_req(ram_trap_req));
    scrf_line_peer u_scrf_line_peer (.clk(clk), .go(go), .data(byte_q), .line(rx_line),
        .busy(busy));
    always @(posedge clk) if (ram_trap_req === 1'b1) traps++;
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so look just after that edge
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
        input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata & m);
    endtask
    task automatic pin_chk(input logic eo);
        repeat (2) @(posedge clk);
        #1;
        chk("pin_oe", 16'h0001, {15'h0, tx_pin_oe});
        chk("pin_o", {15'h0, eo}, {15'h0, tx_pin_o});
    endtask
    // frame, then a full idle span so the next start edge is legal
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        byte_q <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (int k = 0; k < 400 && busy === 1'b1; k++) @(posedge clk);
        repeat ((`SCRF_IDLE_BITS + 2) * `SCRF_BIT_CYC) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(`SCRF_REG_PINCTRL, 16'h0007, 16'h0001, "pinctrl_rst");
        rd_chk(`SCRF_REG_RXCFG, 16'h007F, 16'h0010, "rxcfg_rst");
        chk("oe_rst", 16'h0000, {15'h0, tx_pin_oe});
        rd_chk(4'hF, 16'hFFFF, 16'h0000, "unmapped");
        for (int m = 0; m < 6; m++) begin
            wr_reg(`SCRF_REG_CTRL, 16'(m));
            rd_chk(`SCRF_REG_STATUS, 16'h0040, (m > 0 && m < 5) ? 16'h0040 : 16'h0000,
                "enabled");
        end
        // alternate select while the channel is off must leave the software level on the pin
        wr_reg(`SCRF_REG_PINCTRL, 16'h0006);
        pin_chk(1'b0);
        wr_reg(`SCRF_REG_PINCTRL, 16'h0003);
        wr_reg(`SCRF_REG_CTRL, 16'h0001);
        wr_reg(`SCRF_REG_PINCTRL, 16'h0007);
        pin_chk(1'b1);
        wr_reg(`SCRF_REG_PINCTRL, 16'h0003);
        wr_reg(`SCRF_REG_CTRL, 16'h0000);
        pin_chk(1'b1);
        wr_reg(`SCRF_REG_CTRL, 16'h0001);
        wr_reg(`SCRF_REG_PINCTRL, 16'h0006);
        pin_chk(1'b1);
        wr_reg(`SCRF_REG_PINCTRL, 16'h0003);
        wr_reg(`SCRF_REG_CTRL, 16'h0000);
        $display("test modes and pins done");
        // leave odd-parity words in slots 1 to 3, then drain back to slot 0
        wr_reg(`SCRF_REG_RXCFG, 16'h0040);
        wr_reg(`SCRF_REG_CTRL, 16'h0020);
        for (int i = 0; i < 64; i++) begin
            wr_reg(`SCRF_REG_FIFO_IN, 16'(i > 0 && i < 4));
        end
        for (int i = 0; i < 64; i++) begin
            rd_chk(`SCRF_REG_FIFO_OUT, 16'hFFFF, 16'(i > 0 && i < 4), "drain");
        end
        wr_reg(`SCRF_REG_RXCFG, 16'h0002);
        wr_reg(`SCRF_REG_CTRL, 16'h0012);
        repeat ((`SCRF_IDLE_BITS + 2) * `SCRF_BIT_CYC) @(posedge clk);
        send(8'hA5);
        rd_chk(`SCRF_REG_FIFO_OUT, 16'hFFFF, 16'h00A5, "rx0");
        rd_chk(`SCRF_REG_STATUS, 16'h000A, 16'h000A, "false_parity");
        chk("trap_on", 16'h0001, 16'(traps));
        wr_reg(`SCRF_REG_STATUS, 16'h0003);
        send(8'h3C);
        rd_chk(`SCRF_REG_FILLCNT, 16'h007F, 16'h0002, "fillcnt");
        rd_chk(`SCRF_REG_FIFO_OUT, 16'hFFFF, 16'h003C, "rx1");
        rd_chk(`SCRF_REG_STATUS, 16'h000A, 16'h0008, "parity");
        chk("traps", 16'h0001, 16'(traps));
        $display("test receive fifo done");
        wr_reg(`SCRF_REG_RXCFG, 16'h0040);
        wr_reg(`SCRF_REG_CTRL, 16'h0020);
        for (int i = 0; i < 64; i++) begin
            wr_reg(`SCRF_REG_FIFO_IN, 16'h0000);
        end
        for (int i = 0; i < 64; i++) begin
            rd_chk(`SCRF_REG_FIFO_OUT, 16'hFFFF, 16'h0000, "zero");
        end
        wr_reg(`SCRF_REG_RXCFG, 16'h0010);
        wr_reg(`SCRF_REG_CTRL, 16'h0012);
        wr_reg(`SCRF_REG_STATUS, 16'h0000);
        rd_chk(`SCRF_REG_STATUS, 16'h0021, 16'h0020, "idle_clr");
        send(8'h55);
        rd_chk(`SCRF_REG_STATUS, 16'h0004, 16'h0004, "frame_err");
        rd_chk(`SCRF_REG_FILLCNT, 16'h007F, 16'h0002, "blocked");
        rd_chk(`SCRF_REG_STATUS, 16'h0021, 16'h0001, "idle_back");
        send(8'h81);
        rd_chk(`SCRF_REG_FIFO_OUT, 16'hFFFF, 16'h0081, "rx2");
        rd_chk(`SCRF_REG_STATUS, 16'h0002, 16'h0000, "zeroed_parity");
        chk("traps_end", 16'h0001, 16'(traps));
        $display("test idle done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end
endmodule
